// file: hw/setpoint_gen.sv
// Ramp generator and XY lookup table producing a voltage or current setpoint.
// Assumes one clock, measured values scaled so full code is 125% of nominal.
`timescale 1ns/10ps
`include "setpoint_gen_cfg.svh"
module setpoint_gen
   import setpoint_gen_pkg::*;
#(
   parameter int SP_W = 16,
   parameter int ENTRIES = `SG_TABLE_ENTRIES,
   parameter int TICK_CYC = `SG_TICK_CYC,
   parameter longint HOLD_TICKS = `SG_HOLD_TICKS
)(
   input wire logic clock,
   input wire logic sys_rst,
   // Ramp control
   input wire logic ramp_start,
   input wire logic ramp_stop,
   input wire logic [SP_W-1:0] ramp_start_value,
   input wire logic [SP_W-1:0] ramp_end_value,
   input wire logic [31:0] ramp_delay_time,
   input wire logic [31:0] ramp_duration,
   output logic ramp_active,
   output logic ramp_done,
   output logic [SP_W-1:0] ramp_setpoint,
   // Table function
   input wire logic table_enable,
   input wire logic table_mode,
   input wire logic [SP_W-1:0] nominal_voltage,
   input wire logic [SP_W-1:0] nominal_current,
   input wire logic [11:0] meas_current,
   input wire logic [11:0] meas_voltage,
   output logic [SP_W-1:0] voltage_setpoint,
   output logic [SP_W-1:0] current_setpoint,
   output logic table_valid,
   // Table loading
   input wire logic [4:0] files_found,
   output logic [3:0] files_offered,
   input wire logic load_begin,
   input wire logic load_name_voltage_indexed,
   input wire logic load_entry_valid,
   input wire logic [SP_W-1:0] load_entry,
   input wire logic load_end,
   output logic load_busy,
   output logic load_error,
   output logic load_ok
);
   localparam int IDX_W = $clog2(ENTRIES);
   localparam int CURR_LAST = `SG_CURR_LAST_INDEX;
   localparam int TICK_W = $clog2(TICK_CYC + 1);

   // Hold counter is 32 bits wide
   if (ENTRIES != `SG_TABLE_ENTRIES || SP_W < 2 || TICK_CYC < 1 || HOLD_TICKS < 1
       || HOLD_TICKS > 64'h00000000FFFFFFFF)
   begin : g_bad_params
      $error("setpoint_gen: unsupported parameter values");
   end

   // Sample tick: 0.01 ms period, the time unit of delay and duration
   logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
   logic tick;
   always_comb
   begin
      tick = (tick_cnt_q == TICK_W'(TICK_CYC - 1));
      tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;
   end
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         tick_cnt_q <= '0;
      else
         tick_cnt_q <= tick_cnt_d;
   end

   // Ramp engine
   ramp_state_t ramp_state_q, ramp_state_d;
   logic [31:0] ramp_cnt_q, ramp_cnt_d;
   logic [SP_W-1:0] sp_q, sp_d;
   logic done_q, done_d;
   logic [31:0] dly_clamped, dur_clamped;
   logic [SP_W+31:0] span_mul;
   logic [SP_W-1:0] span, step_ofs;

   function automatic logic [31:0] clamp_time(input logic [31:0] t);
      if (t < 32'(`SG_TIME_MIN_TICKS))
         clamp_time = 32'(`SG_TIME_MIN_TICKS);
      else if (t > 32'(`SG_TIME_MAX_TICKS))
         clamp_time = 32'(`SG_TIME_MAX_TICKS);
      else
         clamp_time = t;
   endfunction

   always_comb
   begin
      dly_clamped = clamp_time(ramp_delay_time);
      dur_clamped = clamp_time(ramp_duration);
      span = (ramp_end_value >= ramp_start_value) ? ramp_end_value - ramp_start_value
                                                  : ramp_start_value - ramp_end_value;
      // Divide is costly and combinational, evaluated every cycle; only its value on a sample tick is used
      span_mul = (SP_W+32)'(span) * (SP_W+32)'(ramp_cnt_q);
      step_ofs = SP_W'(span_mul / (SP_W+32)'(dur_clamped));
      ramp_state_d = ramp_state_q;
      ramp_cnt_d = ramp_cnt_q;
      sp_d = sp_q;
      done_d = done_q;
      if (ramp_stop)
      begin
         ramp_state_d = RAMP_IDLE;
         done_d = 1'b0;
      end
      else
      begin
         case (ramp_state_q)
            RAMP_IDLE:
            begin
               if (ramp_start)
               begin
                  ramp_state_d = RAMP_DELAY;
                  ramp_cnt_d = '0;
                  sp_d = ramp_start_value;
                  done_d = 1'b0;
               end
            end
            RAMP_DELAY:
            begin
               if (tick)
               begin
                  if (ramp_cnt_q + 1 >= dly_clamped)
                  begin
                     ramp_state_d = RAMP_RUN;
                     ramp_cnt_d = '0;
                  end
                  else
                     ramp_cnt_d = ramp_cnt_q + 1;
               end
            end
            RAMP_RUN:
            begin
               if (tick)
               begin
                  sp_d = (ramp_end_value >= ramp_start_value) ? ramp_start_value + step_ofs
                                                              : ramp_start_value - step_ofs;
                  if (ramp_cnt_q >= dur_clamped)
                  begin
                     sp_d = ramp_end_value;
                     ramp_state_d = RAMP_HOLD;
                     ramp_cnt_d = '0;
                  end
                  else
                     ramp_cnt_d = ramp_cnt_q + 1;
               end
            end
            RAMP_HOLD:
            begin
               if (tick)
               begin
                  if (ramp_cnt_q + 1 >= 32'(HOLD_TICKS))
                  begin
                     ramp_state_d = RAMP_IDLE;
                     done_d = 1'b1;
                  end
                  else
                     ramp_cnt_d = ramp_cnt_q + 1;
               end
            end
            default:
               ramp_state_d = RAMP_IDLE;
         endcase
      end
      if (ramp_state_d == RAMP_IDLE)
         sp_d = `SG_SETPOINT_ZERO;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         ramp_state_q <= RAMP_IDLE;
         ramp_cnt_q <= '0;
         sp_q <= `SG_SETPOINT_ZERO;
         done_q <= 1'b0;
      end
      else
      begin
         ramp_state_q <= ramp_state_d;
         ramp_cnt_q <= ramp_cnt_d;
         sp_q <= sp_d;
         done_q <= done_d;
      end
   end

   assign ramp_active = (ramp_state_q != RAMP_IDLE);
   assign ramp_setpoint = sp_q;
   assign ramp_done = done_q;

   // Table storage: entries written into a shadow copy; active copy swapped on success
   logic [SP_W-1:0] table_mem [2][ENTRIES];
   load_state_t load_state_q, load_state_d;
   logic act_bank_q, act_bank_d;
   logic valid_q, valid_d;
   table_mode_t valid_mode_q, valid_mode_d;
   logic [IDX_W:0] wr_cnt_q, wr_cnt_d;
   logic bad_q, bad_d, err_q, err_d, ok_q, ok_d;
   logic [SP_W-1:0] entry_limit;
   logic wr_en;

   always_comb
   begin
      // Entries judged against the model nominal, never user limits
      entry_limit = (table_mode == MODE_CURRENT_INDEXED) ? nominal_voltage
                                                        : nominal_current;
      load_state_d = load_state_q;
      act_bank_d = act_bank_q;
      valid_d = valid_q;
      valid_mode_d = valid_mode_q;
      wr_cnt_d = wr_cnt_q;
      bad_d = bad_q;
      err_d = 1'b0;
      ok_d = 1'b0;
      wr_en = 1'b0;
      case (load_state_q)
         LOAD_IDLE:
         begin
            if (load_begin)
            begin
               wr_cnt_d = '0;
               // Wrong-mode prefix refused outright
               if (load_name_voltage_indexed != table_mode)
                  err_d = 1'b1;
               else
               begin
                  bad_d = 1'b0;
                  load_state_d = LOAD_FILL;
               end
            end
         end
         LOAD_FILL:
         begin
            if (load_entry_valid)
            begin
               if (wr_cnt_q >= (IDX_W+1)'(ENTRIES) || load_entry > entry_limit)
                  bad_d = 1'b1;
               else
                  wr_en = 1'b1;
               wr_cnt_d = wr_cnt_q + 1'b1;
            end
            if (load_end)
               load_state_d = LOAD_DONE;
         end
         LOAD_DONE:
         begin
            load_state_d = LOAD_IDLE;
            if (bad_q || wr_cnt_q != (IDX_W+1)'(ENTRIES))
               err_d = 1'b1;
            else
            begin
               ok_d = 1'b1;
               act_bank_d = ~act_bank_q;
               valid_d = 1'b1;
               valid_mode_d = table_mode_t'(table_mode);
            end
         end
         default:
            load_state_d = LOAD_IDLE;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         load_state_q <= LOAD_IDLE;
         act_bank_q <= 1'b0;
         valid_q <= 1'b0;
         valid_mode_q <= MODE_CURRENT_INDEXED;
         wr_cnt_q <= '0;
         bad_q <= 1'b0;
         err_q <= 1'b0;
         ok_q <= 1'b0;
      end
      else
      begin
         load_state_q <= load_state_d;
         act_bank_q <= act_bank_d;
         valid_q <= valid_d;
         valid_mode_q <= valid_mode_d;
         wr_cnt_q <= wr_cnt_d;
         bad_q <= bad_d;
         err_q <= err_d;
         ok_q <= ok_d;
      end
   end

   always_ff @(posedge clock)
   begin
      if (wr_en)
         table_mem[~act_bank_q][wr_cnt_q[IDX_W-1:0]] <= load_entry;
   end

   assign load_busy = (load_state_q != LOAD_IDLE);
   assign load_error = err_q;
   assign load_ok = ok_q;
   assign table_valid = valid_q && (valid_mode_q == table_mode_t'(table_mode));
   assign files_offered = (files_found > 5'(`SG_LIST_MAX)) ? 4'(`SG_LIST_MAX)
                                                          : files_found[3:0];

   // Lookup: measured code spans 0..125% so index equals the code, capped at CURR_LAST-1 in current mode
   logic [IDX_W-1:0] rd_idx;
   logic [SP_W-1:0] rd_q, vsp_q, vsp_d, isp_q, isp_d;
   logic cur_mode;
   always_comb
   begin
      cur_mode = (table_mode == MODE_CURRENT_INDEXED);
      // Reachable entries count from one, so code CURR_LAST-1 is the last one read
      if (cur_mode)
         rd_idx = (meas_current > 12'(CURR_LAST - 1)) ? IDX_W'(CURR_LAST - 1)
                                                      : meas_current;
      else
         rd_idx = meas_voltage;
      vsp_d = `SG_SETPOINT_ZERO;
      isp_d = `SG_SETPOINT_ZERO;
      if (table_enable && table_valid)
      begin
         if (cur_mode)
            vsp_d = rd_q;
         else
            isp_d = rd_q;
      end
   end

   always_ff @(posedge clock)
   begin
      rd_q <= table_mem[act_bank_q][rd_idx];
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         vsp_q <= `SG_SETPOINT_ZERO;
         isp_q <= `SG_SETPOINT_ZERO;
      end
      else
      begin
         vsp_q <= vsp_d;
         isp_q <= isp_d;
      end
   end

   assign voltage_setpoint = vsp_q;
   assign current_setpoint = isp_q;
endmodule // setpoint_gen

// file: hw/setpoint_gen_cfg.svh
// Constants for the ramp and XY table setpoint generator.
// Included by the design; definitions only.
`ifndef SETPOINT_GEN_CFG_SVH
`define SETPOINT_GEN_CFG_SVH
`define SG_CLK_MHZ 125
`define SG_TICK_NS 10000
`define SG_TICK_CYC ((`SG_TICK_NS * `SG_CLK_MHZ) / 1000)
`define SG_TIME_MIN_TICKS 1
`define SG_TIME_MAX_S 36000
// 64-bit arithmetic: 3.6e9 ticks would wrap a 32-bit int
`define SG_TIME_MAX_TICKS (`SG_TIME_MAX_S * 64'h186A0)
`define SG_HOLD_HOURS 10
`define SG_HOLD_TICKS (`SG_HOLD_HOURS * 3600 * 64'h186A0)
`define SG_TABLE_ENTRIES 4096
`define SG_CURR_LAST_INDEX 3277
`define SG_LIST_MAX 10
`define SG_SETPOINT_ZERO 16'h0000
`endif

// file: hw/setpoint_gen_pkg.sv
// Types shared by the setpoint generator.
// Constants live in setpoint_gen_cfg.svh.
package setpoint_gen_pkg;
   typedef enum logic [1:0] {
      RAMP_IDLE,
      RAMP_DELAY,
      RAMP_RUN,
      RAMP_HOLD
   } ramp_state_t;
   typedef enum logic [1:0] {
      LOAD_IDLE,
      LOAD_FILL,
      LOAD_DONE
   } load_state_t;
   typedef enum logic {
      MODE_CURRENT_INDEXED,
      MODE_VOLTAGE_INDEXED
   } table_mode_t;
endpackage

// file: test/meas_model.sv
// Measurement front end model: analog levels to measured codes.
// Levels come from the bench; one cycle of settling delay.
`timescale 1ns/10ps
module meas_model (
   input wire logic clock,
   input wire logic [11:0] cur_level,
   input wire logic [11:0] volt_level,
   output logic [11:0] meas_current,
   output logic [11:0] meas_voltage
);
   // Full code stands for 125 percent of nominal
   always_ff @(posedge clock)
   begin
      meas_current <= cur_level;
      meas_voltage <= volt_level;
   end
endmodule // meas_model

// file: test/setpoint_gen_sva.sv
// Port-level property checker for the setpoint generator.
// Assumes one clock domain and synchronous active high reset.
`timescale 1ns/10ps
module setpoint_gen_sva #(
   parameter int SP_W = 16
)(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic ramp_start,
   input wire logic ramp_stop,
   input wire logic [SP_W-1:0] ramp_start_value,
   input wire logic ramp_active,
   input wire logic ramp_done,
   input wire logic [SP_W-1:0] ramp_setpoint,
   input wire logic table_enable,
   input wire logic table_mode,
   input wire logic [SP_W-1:0] voltage_setpoint,
   input wire logic [SP_W-1:0] current_setpoint,
   input wire logic [4:0] files_found,
   input wire logic [3:0] files_offered,
   input wire logic load_begin,
   input wire logic load_name_voltage_indexed,
   input wire logic load_busy,
   input wire logic load_error,
   input wire logic load_ok
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   property p_start;
      !ramp_active && ramp_start && !ramp_stop |=>
         ramp_active && ramp_setpoint == $past(ramp_start_value);
   endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_stop; ramp_stop |=> ramp_setpoint == '0; endproperty
   a_stop: assert property (p_stop) else $error("stop not zero");
   property p_done; $rose(ramp_done) |-> ramp_setpoint == '0; endproperty
   a_done: assert property (p_done) else $error("done not zero");
   property p_offer;
      files_offered == ((files_found > 5'h0A) ? 4'hA : files_found[3:0]);
   endproperty
   a_offer: assert property (p_offer) else $error("offer count");
   property p_excl; !(load_ok && load_error); endproperty
   a_excl: assert property (p_excl) else $error("ok with error");
   property p_prefix;
      load_begin && !load_busy && (load_name_voltage_indexed != table_mode) |=> load_error;
   endproperty
   a_prefix: assert property (p_prefix) else $error("prefix taken");
   property p_busy;
      load_begin && !load_busy && (load_name_voltage_indexed == table_mode) |=>
         load_busy && !load_error;
   endproperty
   a_busy: assert property (p_busy) else $error("matching load refused");
   property p_off;
      !table_enable [*3] |-> voltage_setpoint == '0 && current_setpoint == '0;
   endproperty
   a_off: assert property (p_off) else $error("disabled output");
   property p_cur; !table_mode [*3] |-> current_setpoint == '0; endproperty
   a_cur: assert property (p_cur) else $error("current out");
   property p_volt; table_mode [*3] |-> voltage_setpoint == '0; endproperty
   a_volt: assert property (p_volt) else $error("voltage out");
   c_done: cover property ($rose(ramp_done));
   c_ok: cover property (load_ok);
   c_err: cover property (load_error);
endmodule // setpoint_gen_sva

bind setpoint_gen setpoint_gen_sva #(.SP_W(SP_W)) chk_i (.clock, .sys_rst, .ramp_start,
   .ramp_stop, .ramp_start_value, .ramp_active, .ramp_done, .ramp_setpoint, .table_enable,
   .table_mode, .voltage_setpoint, .current_setpoint, .files_found, .files_offered,
   .load_begin, .load_name_voltage_indexed, .load_busy, .load_error, .load_ok);

// file: test/tb_ramp_and_xy_table_setpoint_gen.sv
// Self-checking bench for the ramp and XY table setpoint generator.
// Short tick and hold parameters keep the run brief.
`timescale 1ns/10ps
module tb_ramp_and_xy_table_setpoint_gen;
   localparam int TICK = 2;
   localparam int HOLD = 5;
   localparam logic [15:0] NOMV = 16'h1000;
   localparam logic [15:0] NOMI = 16'h2000;
   logic clock, sys_rst, ramp_start, ramp_stop, table_enable, table_mode, at_end, load_seen;
   logic load_begin, load_name_voltage_indexed, load_entry_valid, load_end;
   logic ramp_active, ramp_done, table_valid, load_busy, load_error, load_ok;
   logic [15:0] ramp_start_value, ramp_end_value, ramp_setpoint, voltage_setpoint;
   logic [15:0] current_setpoint, load_entry;
   logic [31:0] ramp_delay_time, ramp_duration;
   logic [11:0] meas_current, meas_voltage, cur_level, volt_level;
   logic [4:0] files_found;
   logic [3:0] files_offered;
   int err_count, samples_checked;
   setpoint_gen #(.TICK_CYC(TICK), .HOLD_TICKS(HOLD)) DUT (.clock, .sys_rst, .ramp_start,
      .ramp_stop, .ramp_start_value, .ramp_end_value, .ramp_delay_time, .ramp_duration,
      .ramp_active, .ramp_done, .ramp_setpoint, .table_enable, .table_mode,
      .nominal_voltage(NOMV), .nominal_current(NOMI), .meas_current, .meas_voltage,
      .voltage_setpoint, .current_setpoint, .table_valid, .files_found, .files_offered,
      .load_begin, .load_name_voltage_indexed, .load_entry_valid, .load_entry, .load_end,
      .load_busy, .load_error, .load_ok);
   meas_model meas (.clock, .cur_level, .volt_level, .meas_current, .meas_voltage);
   always_comb at_end = (ramp_setpoint === ramp_end_value);
   always_comb load_seen = load_ok | load_error;
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // First look is at a falling edge, never in the launching edge's time step
   task automatic wait_hi(ref logic s, input int n);
      @(negedge clock);
      for (int i = 0; i < n && s !== 1'b1; i++)
         @(negedge clock);
      if (s !== 1'b1)
      begin
         err_count++;
         complete_run();
      end
   endtask
   task automatic ramp(input logic [15:0] a, input logic [15:0] b, input int d, input int t);
      @(posedge clock);
      ramp_start_value <= a; // Static level before start is zero
      ramp_end_value <= b;
      ramp_delay_time <= d;
      ramp_duration <= t;
      ramp_start <= 1'b1;
      @(posedge clock);
      ramp_start <= 1'b0;
      @(negedge clock);
   endtask
   // Odd entries jump to the top value, so neighbour steps are large
   task automatic load(input logic vi, input int n, input int bad, input logic [15:0] big);
      @(posedge clock);
      load_name_voltage_indexed <= vi;
      load_begin <= 1'b1;
      for (int i = 0; i < n; i++) // One value per cycle, no gaps
      begin
         @(posedge clock);
         load_begin <= 1'b0;
         load_entry_valid <= 1'b1;
         load_entry <= (i == bad) ? big + 16'h0001 : (i % 2 ? big : 16'(i));
         load_end <= (i == n - 1);
      end
      @(posedge clock);
      {load_begin, load_entry_valid, load_end} <= 3'h0;
      wait_hi(load_seen, 8);
   endtask
   task automatic t_ramp;
      ramp(16'h0064, 16'h012C, 2, 4);
      chk(ramp_setpoint, 16'h0064);
      repeat (2 * TICK - 1) @(negedge clock);
      chk(ramp_setpoint, 16'h0064);
      wait_hi(at_end, 12 * TICK);
      repeat (HOLD * TICK - 2) @(negedge clock);
      chk(ramp_setpoint, 16'h012C);
      wait_hi(ramp_done, 4 * TICK);
      chk(ramp_setpoint, 16'h0000);
      repeat (20) @(negedge clock);
      chk(ramp_active, 1'b0);
      ramp(16'h012C, 16'h0064, 1, 20);
      repeat (12 * TICK) @(negedge clock);
      chk(ramp_setpoint < 16'h012C && ramp_setpoint > 16'h0064, 1'b1);
      @(posedge clock);
      ramp_stop <= 1'b1;
      @(posedge clock);
      ramp_stop <= 1'b0;
      @(negedge clock);
      chk(ramp_setpoint, 16'h0000);
      $display("ramp tests done");
   endtask
   task automatic t_table;
      load(1'b0, 4096, -1, NOMV);
      chk(load_ok, 1'b1);
      chk(table_valid, 1'b1);
      @(posedge clock);
      table_enable <= 1'b1;
      cur_level <= 12'h006;
      repeat (6) @(negedge clock);
      chk(voltage_setpoint, 16'h0006);
      @(posedge clock);
      cur_level <= 12'hFA0;
      repeat (6) @(negedge clock);
      chk(voltage_setpoint, 16'h0CCC);
      load(1'b0, 4096, -1, 16'h1800);
      chk(load_error, 1'b1);
      load(1'b0, 4095, -1, NOMV);
      chk(load_error, 1'b1);
      load(1'b0, 4096, 77, NOMV);
      chk(load_error, 1'b1);
      load(1'b1, 0, -1, NOMV);
      chk(load_error, 1'b1);
      repeat (3) @(negedge clock);
      chk(voltage_setpoint, 16'h0CCC);
      @(posedge clock);
      table_mode <= 1'b1;
      load(1'b1, 4096, -1, 16'h1800);
      chk(load_ok, 1'b1);
      @(posedge clock);
      volt_level <= 12'h009;
      repeat (6) @(negedge clock);
      chk(current_setpoint, 16'h1800);
      chk(voltage_setpoint, 16'h0000);
      $display("table tests done");
   endtask
   task automatic t_files;
      for (int n = 0; n < 32; n++)
      begin
         @(posedge clock);
         files_found <= 5'(n);
         @(negedge clock);
         chk(files_offered, (n > 10) ? 16'h000A : 16'(n));
      end
      $display("file list test done");
   endtask
   initial
   begin
      sys_rst = 1'b1;
      {ramp_start, ramp_stop, table_enable, table_mode, load_begin} = 5'h00;
      {load_name_voltage_indexed, load_entry_valid, load_end} = 3'h0;
      {ramp_start_value, ramp_end_value, load_entry} = 48'h0;
      {ramp_delay_time, ramp_duration} = 64'h1;
      {cur_level, volt_level, files_found} = 29'h0;
      err_count = 0;
      samples_checked = 0;
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      @(negedge clock);
      chk(table_valid, 1'b0);
      t_ramp();
      t_table();
      t_files();
      complete_run();
   end
endmodule // tb_ramp_and_xy_table_setpoint_gen
